// File: include/rcas_consts.svh
`ifndef RCAS_CONSTS_SVH
`define RCAS_CONSTS_SVH

// ***************************************
// Register byte addresses
// ***************************************
`define RCAS_ADDR_LOW_OFS 32'h40000024
`define RCAS_ADDR_HIGH_OFS 32'h40000028
`define RCAS_POINTERS_OFS 32'h4000002C
`define RCAS_SLEEP_CTL_OFS 32'h40000030
`define RCAS_SLEEP_LEN_OFS 32'h40000034

// ***************************************
// Field positions
// ***************************************
`define RCAS_PRIVATE_BIT 16
`define RCAS_ETAB_LSB 16
`define RCAS_EXT_WAKE_DIS_BIT 31
`define RCAS_SLEEP_STAT_BIT 15
`define RCAS_SOFT_WAKE_BIT 4
`define RCAS_CORR_BIT 3
`define RCAS_SLEEP_REQ_BIT 2

// ***************************************
// Reset word and wake irq enable mask
// ***************************************
`define RCAS_RESET_WORD 32'h00000000
`define RCAS_IRQ_EN_ALL 2'h3

`endif

// File: include/rcas_pkg.sv
package rcas_pkg;

  // Register bus request, one beat
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rcas_bus_req_type;

  // Deep sleep sequencer states
  typedef enum logic [1:0] {
    RCAS_ACTIVE,
    RCAS_SLEEP,
    RCAS_WOKEN
  } rcas_state_type;

endpackage

// File: logic/rcas_regs.sv
// Function
// - Low 32 bits of own link address, read/write, reset zero.
// - High 16 bits of own address in bits 15:0, read/write.
// - Bit 16 of high address word flags private (1) or public (0).
// - Exchange table start pointer, 16 bits in 31:16, read/write.
// - Receive descriptor list start pointer, 15 bits in 14:0.
// - Bit 31 set makes external wake requests ignored.
// - Read-only bit 15 shows deep sleep is in progress.
// - Writing 1 to bit 4 in sleep wakes the core; self clears.
// - Writing 1 to bit 3 after wake corrects time and restarts counters.
// - Bit 2 set requests deep sleep; 0 means normal operation.
// - Sleep request bit clears itself when the sleep status falls.
// - A 32-bit count sets low-power cycles spent asleep before waking.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "rcas_consts.svh"

module rcas_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire rcas_pkg::rcas_bus_req_type bus_req,
  output logic [31:0] rd_data,
  // Pins from outside the clock domain
  input wire logic lp_clk_pin,
  input wire logic ext_wake_pin,
  // Configuration to the link core
  output logic [47:0] own_address,
  output logic address_is_private,
  output logic [15:0] exchange_table_start,
  output logic [14:0] rx_descriptor_list_start,
  // Sleep status and events
  output logic deep_sleep_active,
  output logic counters_enable,
  output logic time_correction_pulse,
  output logic low_power_wake_irq
);
  import rcas_pkg::*;

  // ***************************************
  // Address decode
  // ***************************************
  logic [31:0] addr_low_reg;
  logic [16:0] addr_high_reg;
  logic [15:0] etab_reg;
  logic [14:0] rxd_reg;
  logic ext_dis_reg;
  logic sleep_req_reg;
  logic [1:0] irq_en_reg;
  logic [31:0] sleep_len_reg;
  logic [31:0] sleep_cnt_reg;
  logic [31:0] rd_data_reg;
  logic deep_sleep_reg;
  logic corr_pulse_reg;
  logic cnt_en_reg;
  logic wake_irq_reg;
  rcas_state_type state_reg;
  rcas_state_type state_next;

  // Decode per register; a hit on nothing returns zero
  wire sel_low = (bus_req.addr == `RCAS_ADDR_LOW_OFS);
  wire sel_high = (bus_req.addr == `RCAS_ADDR_HIGH_OFS);
  wire sel_ptr = (bus_req.addr == `RCAS_POINTERS_OFS);
  wire sel_ctl = (bus_req.addr == `RCAS_SLEEP_CTL_OFS);
  wire sel_len = (bus_req.addr == `RCAS_SLEEP_LEN_OFS);
  wire wr_low = bus_req.wr && sel_low;
  wire wr_high = bus_req.wr && sel_high;
  wire wr_ptr = bus_req.wr && sel_ptr;
  wire wr_ctl = bus_req.wr && sel_ctl;
  wire wr_len = bus_req.wr && sel_len;

  // ***************************************
  // Pin synchronisers
  // ***************************************
  logic lp_s1_reg;
  logic lp_s2_reg;
  logic lp_s3_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;

  // Two flops before use; only s2/s3 feed the edge detector
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lp_s1_reg <= 1'b0;
      lp_s2_reg <= 1'b0;
      lp_s3_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      lp_s1_reg <= lp_clk_pin;
      lp_s2_reg <= lp_s1_reg;
      lp_s3_reg <= lp_s2_reg;
      ext_s1_reg <= ext_wake_pin;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // Low-power clock rising edge as a core-clock tick
  wire lp_tick = lp_s2_reg && !lp_s3_reg;

  // ***************************************
  // Wake sources and sleep sequencing
  // ***************************************
  wire [32:0] cnt_inc = {1'b0, sleep_cnt_reg} + 33'h000000001;
  // Length zero wakes on the first low-power tick
  wire timer_wake = lp_tick && (cnt_inc >= {1'b0, sleep_len_reg});
  wire soft_wake = wr_ctl && bus_req.wdata[`RCAS_SOFT_WAKE_BIT];
  wire ext_wake = ext_s2_reg && !ext_dis_reg;
  wire any_wake = timer_wake || soft_wake || ext_wake;
  wire corr_write = wr_ctl && bus_req.wdata[`RCAS_CORR_BIT];

  // Sleep sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RCAS_ACTIVE: begin
        if (sleep_req_reg) begin
          state_next = RCAS_SLEEP;
        end
      end
      RCAS_SLEEP: begin
        if (any_wake) begin
          state_next = RCAS_WOKEN;
        end
      end
      RCAS_WOKEN: begin
        // Counters stay frozen until software corrects the time base
        if (corr_write) begin
          state_next = RCAS_ACTIVE;
        end
      end
      default: begin
        state_next = RCAS_ACTIVE;
      end
    endcase
  end

  wire entering = (state_reg != RCAS_SLEEP) && (state_next == RCAS_SLEEP);
  // Falling edge of the status flag, as seen at the flop input
  wire stat_fall = deep_sleep_reg && (state_next != RCAS_SLEEP);
  wire set_req = wr_ctl && bus_req.wdata[`RCAS_SLEEP_REQ_BIT];
  wire clr_req = wr_ctl && !bus_req.wdata[`RCAS_SLEEP_REQ_BIT];

  // State, status flag and sleep counter
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= RCAS_ACTIVE;
      deep_sleep_reg <= 1'b0;
      sleep_cnt_reg <= `RCAS_RESET_WORD;
    end else begin
      state_reg <= state_next;
      deep_sleep_reg <= (state_next == RCAS_SLEEP);
      if (entering) begin
        sleep_cnt_reg <= `RCAS_RESET_WORD;
      end else if (state_reg == RCAS_SLEEP && lp_tick) begin
        sleep_cnt_reg <= cnt_inc[31:0];
      end
    end
  end

  // Sleep request: a write setting it wins over the self clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sleep_req_reg <= 1'b0;
    end else if (set_req) begin
      sleep_req_reg <= 1'b1;
    end else if (clr_req || stat_fall) begin
      sleep_req_reg <= 1'b0;
    end
  end

  // Event outputs
  always_ff @(posedge clock) begin
    if (!rstn) begin
      corr_pulse_reg <= 1'b0;
      cnt_en_reg <= 1'b1;
      wake_irq_reg <= 1'b0;
    end else begin
      corr_pulse_reg <= (state_reg == RCAS_WOKEN) && corr_write;
      cnt_en_reg <= (state_next == RCAS_ACTIVE);
      // Gated by the field software arms before sleeping
      wake_irq_reg <= stat_fall && (irq_en_reg != 2'h0);
    end
  end

  // ***************************************
  // Software registers
  // ***************************************
  // Address and pointer fields; bits without a field are dropped
  always_ff @(posedge clock) begin
    if (!rstn) begin
      addr_low_reg <= `RCAS_RESET_WORD;
      addr_high_reg <= 17'h00000;
      etab_reg <= 16'h0000;
      rxd_reg <= 15'h0000;
    end else begin
      if (wr_low) begin
        addr_low_reg <= bus_req.wdata;
      end
      if (wr_high) begin
        addr_high_reg <= bus_req.wdata[16:0];
      end
      if (wr_ptr) begin
        etab_reg <= bus_req.wdata[31:16];
        rxd_reg <= bus_req.wdata[14:0];
      end
    end
  end

  // Sleep control fields and the sleep length
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ext_dis_reg <= 1'b0;
      irq_en_reg <= 2'h0;
      sleep_len_reg <= `RCAS_RESET_WORD;
    end else begin
      if (wr_ctl) begin
        ext_dis_reg <= bus_req.wdata[`RCAS_EXT_WAKE_DIS_BIT];
        irq_en_reg <= bus_req.wdata[1:0];
      end
      if (wr_len) begin
        sleep_len_reg <= bus_req.wdata;
      end
    end
  end

  // ***************************************
  // Read path
  // ***************************************
  // Wake and correction strobes act at once, so they read zero
  wire [31:0] ctl_word = {ext_dis_reg, 15'h0000, deep_sleep_reg, 10'h000, 2'h0,
    sleep_req_reg, irq_en_reg};
  wire [31:0] rd_mux = sel_low ? addr_low_reg
    : sel_high ? {15'h0000, addr_high_reg}
    : sel_ptr ? {etab_reg, 1'b0, rxd_reg}
    : sel_ctl ? ctl_word
    : sel_len ? sleep_len_reg
    : `RCAS_RESET_WORD;

  // Read data valid only the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_data_reg <= `RCAS_RESET_WORD;
    end else begin
      rd_data_reg <= bus_req.rd ? rd_mux : `RCAS_RESET_WORD;
    end
  end

  // Outputs straight from flops
  assign rd_data = rd_data_reg;
  assign own_address = {addr_high_reg[15:0], addr_low_reg};
  assign address_is_private = addr_high_reg[`RCAS_PRIVATE_BIT];
  assign exchange_table_start = etab_reg;
  assign rx_descriptor_list_start = rxd_reg;
  assign deep_sleep_active = deep_sleep_reg;
  assign counters_enable = cnt_en_reg;
  assign time_correction_pulse = corr_pulse_reg;
  assign low_power_wake_irq = wake_irq_reg;

  // ***************************************
  // Checks
  // ***************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Write to the low address word, then checked at own_address
  sequence low_write_s;
    bus_req.wr && bus_req.addr == `RCAS_ADDR_LOW_OFS;
  endsequence

  // Counters restart with the pulse; the pulse drops after one cycle
  sequence corr_seq_s;
    (time_correction_pulse && counters_enable) ##1 !time_correction_pulse;
  endsequence

  addr_low_store_a: assert property (
    low_write_s |=> own_address[31:0] == $past(bus_req.wdata))
    else $error("low address word not stored");

  addr_high_store_a: assert property (
    wr_high |=> own_address[47:32] == $past(bus_req.wdata[15:0]))
    else $error("high address half not stored");

  private_flag_a: assert property (
    wr_high |=> address_is_private == $past(bus_req.wdata[16]))
    else $error("private flag not stored");

  pointers_store_a: assert property (
    wr_ptr |=> exchange_table_start == $past(bus_req.wdata[31:16])
      && rx_descriptor_list_start == $past(bus_req.wdata[14:0]))
    else $error("pointers not stored");

  ext_wake_block_a: assert property (
    state_reg == RCAS_SLEEP && ext_dis_reg && !soft_wake && !timer_wake
      |=> deep_sleep_active)
    else $error("external wake not blocked");

  sleep_status_read_a: assert property (
    bus_req.rd && sel_ctl |=> rd_data[15] == $past(deep_sleep_active))
    else $error("sleep status misread");

  soft_wake_a: assert property (
    state_reg == RCAS_SLEEP && soft_wake |=> !deep_sleep_active && !counters_enable)
    else $error("software wake ignored");

  correction_a: assert property (
    state_reg == RCAS_WOKEN && corr_write |=> corr_seq_s)
    else $error("correction not applied");

  sleep_entry_a: assert property (
    state_reg == RCAS_ACTIVE && sleep_req_reg |=> deep_sleep_active)
    else $error("sleep request not honoured");

  req_self_clear_a: assert property (
    $fell(deep_sleep_active) && !$past(set_req) |-> !sleep_req_reg)
    else $error("sleep request not cleared on wake");

  timer_expiry_a: assert property (
    state_reg == RCAS_SLEEP && timer_wake |=> !deep_sleep_active)
    else $error("sleep timer expiry missed");

  reserved_zero_a: assert property (
    bus_req.rd && sel_high |=> rd_data[31:17] == 15'h0000)
    else $error("reserved bits not zero");

  // Enabled external wake must end sleep at the next edge
  ext_wake_take_a: assert property (
    state_reg == RCAS_SLEEP && ext_s2_reg && !ext_dis_reg |=> !deep_sleep_active)
    else $error("external wake not taken");

  asleep_frozen_a: assert property (
    deep_sleep_active |-> !counters_enable)
    else $error("counters running in deep sleep");

  corr_refused_a: assert property (
    state_reg != RCAS_WOKEN |=> !time_correction_pulse)
    else $error("correction outside woken state");

  // Wake pulse follows the enable field armed before sleeping
  wake_irq_a: assert property (
    $fell(deep_sleep_active) |-> low_power_wake_irq == ($past(irq_en_reg) != 2'h0))
    else $error("wake pulse wrong");

  rd_idle_zero_a: assert property (
    !bus_req.rd |=> rd_data == 32'h00000000)
    else $error("read data outside read slot");

endmodule // rcas_regs

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcas_consts.svh"

module tb_top;
  import rcas_pkg::*;

  // ****************************************
  // Signals and design instance
  // ****************************************
  typedef struct {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } rcas_row_type;

  logic clock;
  logic rstn;
  logic lp_clk_pin;
  logic ext_wake_pin;
  rcas_bus_req_type bus_req;
  logic [31:0] rd_data;
  logic [47:0] own_address;
  logic address_is_private;
  logic [15:0] exchange_table_start;
  logic [14:0] rx_descriptor_list_start;
  logic deep_sleep_active;
  logic counters_enable;
  logic time_correction_pulse;
  logic low_power_wake_irq;
  logic irq_seen;
  int n_mismatch;
  int n_checks;
  int n_irq;
  int irq_base;

  // Undefined bits in rows 2, 3, 4 and 6 must come back as zero
  rcas_row_type rows [6] = '{
    '{`RCAS_ADDR_LOW_OFS, 32'hA5C30F96, 32'hA5C30F96},
    '{`RCAS_ADDR_HIGH_OFS, 32'hFFFFFFFF, 32'h0001FFFF},
    '{`RCAS_POINTERS_OFS, 32'hFFFFFFFF, 32'hFFFF7FFF},
    '{32'h40000038, 32'hFFFFFFFF, 32'h00000000},
    '{`RCAS_SLEEP_LEN_OFS, 32'h00000003, 32'h00000003},
    '{`RCAS_SLEEP_CTL_OFS, 32'h80007FF3, 32'h80000003}};

  rcas_regs u_rcas_regs (
    .clock(clock),
    .rstn(rstn),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .lp_clk_pin(lp_clk_pin),
    .ext_wake_pin(ext_wake_pin),
    .own_address(own_address),
    .address_is_private(address_is_private),
    .exchange_table_start(exchange_table_start),
    .rx_descriptor_list_start(rx_descriptor_list_start),
    .deep_sleep_active(deep_sleep_active),
    .counters_enable(counters_enable),
    .time_correction_pulse(time_correction_pulse),
    .low_power_wake_irq(low_power_wake_irq)
  );

  // ****************************************
  // Clock and shared tasks
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Wake pulses counted on the falling edge, where they are settled
  always @(negedge clock) begin
    if (low_power_wake_irq === 1'b1) begin
      n_irq++;
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; returns on the edge that takes it
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, zero after
  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    check(rd_data, exp);
    @(posedge clock);
    #1;
    check(rd_data, 32'h0);
  endtask

  // Bounded wait for wake, noting any wake pulse on the way
  task wait_wake(input int lim);
    irq_seen = 1'b0;
    for (int i = 0; i < lim && deep_sleep_active !== 1'b0; i++) begin
      @(posedge clock);
      #1;
      irq_seen |= low_power_wake_irq;
    end
  endtask

  // Slow tick, long enough for the two-flop synchroniser
  task lp_tick;
    @(posedge clock);
    lp_clk_pin <= 1'b1;
    repeat (4) @(posedge clock);
    lp_clk_pin <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task conclude;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    lp_clk_pin = 1'b0;
    ext_wake_pin = 1'b0;
    bus_req = '{addr: 32'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
    repeat (15) @(posedge clock);
    #1;
    check({31'h0, counters_enable}, 32'h1);
    @(posedge clock);
    rstn <= 1'b1;
    rd_chk(`RCAS_SLEEP_CTL_OFS, `RCAS_RESET_WORD);
    for (int i = 0; i < 6; i++) begin
      rd_chk(rows[i].a, `RCAS_RESET_WORD);
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    check(own_address[47:32], 16'hFFFF);
    check(own_address[31:0], 32'hA5C30F96);
    check({31'h0, address_is_private}, 32'h1);
    check({16'h0, exchange_table_start}, 32'hFFFF);
    check({17'h0, rx_descriptor_list_start}, 32'h7FFF);
    check({31'h0, time_correction_pulse}, 32'h0);
    // Soft wake path, irq enables set with the request
    wr(`RCAS_SLEEP_CTL_OFS, 32'h00000007);
    @(posedge clock);
    #1;
    check({deep_sleep_active, counters_enable}, 32'h2);
    rd_chk(`RCAS_SLEEP_CTL_OFS, 32'h00008007);
    // Wake write keeps bit 2 low; a set request would win over the self clear
    wr(`RCAS_SLEEP_CTL_OFS, 32'h00000013);
    #1;
    check({deep_sleep_active, low_power_wake_irq}, 32'h1);
    rd_chk(`RCAS_SLEEP_CTL_OFS, 32'h00000003);
    check({31'h0, counters_enable}, 32'h0);
    wr(`RCAS_SLEEP_CTL_OFS, 32'h0000000B);
    #1;
    check({time_correction_pulse, counters_enable}, 32'h3);
    @(posedge clock);
    #1;
    check({31'h0, time_correction_pulse}, 32'h0);
    // External wake blocked, then allowed
    wr(`RCAS_SLEEP_CTL_OFS, 32'h80000007);
    ext_wake_pin <= 1'b1;
    repeat (10) @(posedge clock);
    #1;
    check({31'h0, deep_sleep_active}, 32'h1);
    wr(`RCAS_SLEEP_CTL_OFS, 32'h00000007);
    wait_wake(8);
    check({deep_sleep_active, irq_seen}, 32'h1);
    @(posedge clock);
    ext_wake_pin <= 1'b0;
    wr(`RCAS_SLEEP_CTL_OFS, 32'h00000008);
    // Timer wake after three ticks, wake irq armed with the request
    irq_base = n_irq;
    wr(`RCAS_SLEEP_CTL_OFS, 32'h00000007);
    lp_tick;
    lp_tick;
    #1;
    check({31'h0, deep_sleep_active}, 32'h1);
    lp_tick;
    #1;
    check({31'h0, deep_sleep_active}, 32'h0);
    check(n_irq - irq_base, 32'h1);
    rd_chk(`RCAS_SLEEP_CTL_OFS, 32'h00000003);
    wr(`RCAS_SLEEP_CTL_OFS, 32'h00000008);
    // Reset again in mid-run
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(own_address[31:0], 32'h0);
    check({31'h0, counters_enable}, 32'h1);
    @(posedge clock);
    rstn <= 1'b1;
    rd_chk(`RCAS_POINTERS_OFS, `RCAS_RESET_WORD);
    conclude;
  end

  // Hang guard, well beyond the 150 or so cycles of the tests
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    conclude;
  end
endmodule // tb_top

`default_nettype wire
